/* File: app_pkg.sv */
// Purpose: Shared constants and types for the audio playback path.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   All register reset values are zero.
package app_pkg;

    // Register word indices
    localparam logic [15:0] APP_IDX_RATE_LOW    = 16'hfc34;
    localparam logic [15:0] APP_IDX_RATE_HIGH   = 16'hfc35;
    localparam logic [15:0] APP_IDX_LEFT_LOW    = 16'hfc36;
    localparam logic [15:0] APP_IDX_LEFT_HIGH   = 16'hfc37;
    localparam logic [15:0] APP_IDX_RIGHT_LOW   = 16'hfc38;
    localparam logic [15:0] APP_IDX_RIGHT_HIGH  = 16'hfc39;
    localparam logic [15:0] APP_IDX_ROUTE       = 16'hfc3a;
    localparam logic [15:0] APP_IDX_VOLUME      = 16'hfec0;
    localparam logic [15:0] APP_IDX_MIX_CONFIG  = 16'hfec1;
    localparam logic [15:0] APP_IDX_MIX_L_LOW   = 16'hfec2;
    localparam logic [15:0] APP_IDX_MIX_L_HIGH  = 16'hfec3;
    localparam logic [15:0] APP_IDX_MIX_R_LOW   = 16'hfec4;
    localparam logic [15:0] APP_IDX_MIX_R_HIGH  = 16'hfec5;

    // Field positions
    localparam int APP_MIX_URUN_BIT = 14;
    localparam int APP_MIX_FULL_BIT = 13;
    localparam int APP_MIX_EN_BIT   = 12;

    // Reset values and counts
    localparam logic [15:0] APP_REG_RESET    = 16'h0000;
    localparam logic [6:0]  APP_PRESCALE_TOP = 7'h7f; // 2^27 = 2^20 * 128
    localparam int          APP_FLT_SHIFT    = 3;
    localparam int          APP_FINE_STEPS   = 12;
    localparam int          APP_GAIN_FRAC    = 15;

    // Bus handshake states
    typedef enum logic [1:0]
    {
        APP_BUS_IDLE = 2'b01,
        APP_BUS_ACK  = 2'b10
    } app_bus_type;

    // Whole state of the block
    typedef struct packed
    {
        app_bus_type  bus_state;
        logic         wait_q;
        logic [31:0]  rdata;
        logic [15:0]  rate_lo;
        logic [3:0]   rate_hi;
        logic [7:0]   left_lo;
        logic [15:0]  left_hi;
        logic [7:0]   right_lo;
        logic [15:0]  right_hi;
        logic [15:0]  volume;
        logic         route_mix;
        logic         mix_en;
        logic [11:0]  mix_int;
        logic         full;
        logic         urun;
        logic [3:0]   ml_lo;
        logic [15:0]  ml_hi;
        logic [3:0]   mr_lo;
        logic [15:0]  mr_hi;
        logic         seen_l;
        logic         seen_r;
        logic [6:0]   pre;
        logic [19:0]  acc;
        logic [23:0]  in_l;
        logic [23:0]  in_r;
        logic [23:0]  flt_l;
        logic [23:0]  flt_r;
        logic [23:0]  vol_l;
        logic [23:0]  vol_r;
        logic [19:0]  off_l;
        logic [19:0]  off_r;
        logic [11:0]  mix_cnt;
        logic [19:0]  dac_l;
        logic [19:0]  dac_r;
        logic [23:0]  ser_l;
        logic [23:0]  ser_r;
        logic         clk_en;
        logic         play_irq;
        logic         mix_irq;
    } app_state_type;

endpackage

/* File: app_playback.sv */
// Purpose: Playback path: rate interpolator, volume, offset mixer, bus.
// Assumes: core_clk is the crystal clock; Avalon-MM byte addressing.
// Notes:   Every access answers after one wait cycle; unmapped reads zero.
`timescale 1ns/1ps

// Functional notes
// [R1] Increment: low 16 bits, top 4 bits, two registers.
// [R2] Strobe is carry of 20-bit increment accumulator.
// [R3] Steps at crystal/128; rate crystal/2^27 times increment.
// [R4] Zero increment idles path, stops converter clock.
// [R5] Sample bits 23..8 high register, 7..0 companion byte.
// [R6] Software refills samples after each request.
// [R7] Converter clock is crystal, not PLL.
// [R8] Coarse fields: 6 dB down per unit.
// [R9] Fine fields: 0.5 dB up per unit; 12..15 unity.
// [R10] Registers, filter, volume, converter outputs.
// [R11] Offset samples held until the next.
// [R12] Mix config bit 12 enables offset.
// [R13] Offset bits 19..4 high register, 3..0 companion.
// [R14] Full sets on both offset writes, clears on consume.
// [R15] Underrun sets on consume while not full.
// [R16] Offset sample every interval plus one cycles.
// [R17] Offset consume pulses offset request.
// [R18] Mix saturates to 20-bit signed.
// [R19] Software keeps mix under 75 percent scale.
// [R20] Serial output may carry mixed signal.
// [R21] Sample pair captured together on strobe.
module app_playback
    import app_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [17:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [23:0] ser_direct_left,
    input  wire logic [23:0] ser_direct_right,
    output logic      [19:0] dac_left,
    output logic      [19:0] dac_right,
    output logic             dac_clk_en,
    output logic             play_irq,
    output logic             mix_irq,
    output logic      [23:0] ser_left,
    output logic      [23:0] ser_right
);

    app_state_type st_reg;
    app_state_type st_next;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] app_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
        logic [15:0] r;
        r = old_v;
        if (be[0])
            r[7:0] = new_v[7:0];
        if (be[1])
            r[15:8] = new_v[15:8];
        return r;
    endfunction

    // Fine gain in Q1.15, half-dB steps
    function automatic logic [16:0] app_fine_gain(input logic [3:0] f);
        logic [16:0] g;
        case (f)
            4'h1:    g = 17'h087a6;
            4'h2:    g = 17'h08f9e;
            4'h3:    g = 17'h09821;
            4'h4:    g = 17'h0a125;
            4'h5:    g = 17'h0aab2;
            4'h6:    g = 17'h0b4ce;
            4'h7:    g = 17'h0bf84;
            4'h8:    g = 17'h0cadd;
            4'h9:    g = 17'h0d6e3;
            4'ha:    g = 17'h0e39e;
            4'hb:    g = 17'h0f11b;
            default: g = 17'h08000; // Also 12..15, see [R9]
        endcase
        return g;
    endfunction

    // Clamp to 24-bit signed
    function automatic logic [23:0] app_sat24(input logic signed [26:0] v);
        logic [23:0] r;
        if (v > 27'sh07fffff)
            r = 24'h7fffff;
        else if (v < -27'sh0800000)
            r = 24'h800000;
        else
            r = v[23:0];
        return r;
    endfunction

    // Clamp to 20-bit signed, never wrap
    function automatic logic [19:0] app_sat20(input logic signed [20:0] v);
        logic [19:0] r;
        if (v > 21'sh07ffff)
            r = 20'h7ffff; // see [R18]
        else if (v < -21'sh080000)
            r = 20'h80000; // see [R18]
        else
            r = v[19:0];
        return r;
    endfunction

    // Coarse shift then fine gain
    function automatic logic [23:0] app_volume(input logic [23:0] s,
                                               input logic [3:0]  coarse,
                                               input logic [3:0]  fine);
        logic signed [23:0] sh;
        logic signed [41:0] prod;
        sh = $signed(s) >>> coarse; // see [R8]
        prod = sh * $signed({1'b0, app_fine_gain(fine)}); // see [R9]
        return app_sat24(27'(prod >>> APP_GAIN_FRAC));
    endfunction

    // One-pole smoothing toward the held input
    function automatic logic [23:0] app_smooth(input logic [23:0] y,
                                               input logic [23:0] x);
        logic signed [24:0] d;
        d = $signed({x[23], x}) - $signed({y[23], y});
        return 24'($signed({y[23], y}) + (d >>> APP_FLT_SHIFT));
    endfunction

    // Main plus offset, main scaled to 20 bits
    function automatic logic [19:0] app_mix(input logic [23:0] m,
                                            input logic [19:0] o,
                                            input logic        en);
        logic signed [20:0] sum;
        sum = $signed({m[23], m[23:4]});
        if (en)
            sum = sum + $signed({o[19], o});
        return app_sat20(sum);
    endfunction

    logic [15:0] idx;
    logic [15:0] wdat;
    logic [1:0]  be;
    logic        wr_go;
    logic [15:0] rd;
    logic [19:0] inc;
    logic [20:0] acc_sum;
    logic        strobe;
    logic        consume;
    logic        full_set;
    logic        urun_clr;
    logic        seen_l_now;
    logic        seen_r_now;

    // Next-state logic for the whole block
    always_comb
    begin
        st_next = st_reg;
        idx = avs_address[17:2];
        wdat = avs_writedata[15:0];
        be = avs_byteenable[1:0];
        wr_go = avs_write && (st_reg.bus_state == APP_BUS_ACK);
        rd = APP_REG_RESET;
        full_set = 1'b0;
        urun_clr = 1'b0;
        seen_l_now = st_reg.seen_l;
        seen_r_now = st_reg.seen_r;

        // Readback, unmapped read zero
        case (idx)
            APP_IDX_RATE_LOW:   rd = st_reg.rate_lo;
            APP_IDX_RATE_HIGH:  rd = {12'h000, st_reg.rate_hi};
            APP_IDX_LEFT_LOW:   rd = {st_reg.left_lo, 8'h00};
            APP_IDX_LEFT_HIGH:  rd = st_reg.left_hi;
            APP_IDX_RIGHT_LOW:  rd = {st_reg.right_lo, 8'h00};
            APP_IDX_RIGHT_HIGH: rd = st_reg.right_hi;
            APP_IDX_ROUTE:      rd = {15'h0000, st_reg.route_mix};
            APP_IDX_VOLUME:     rd = st_reg.volume;
            APP_IDX_MIX_CONFIG: rd = {1'b0, st_reg.urun, st_reg.full,
                                      st_reg.mix_en, st_reg.mix_int};
            APP_IDX_MIX_L_LOW:  rd = {st_reg.ml_lo, 12'h000};
            APP_IDX_MIX_L_HIGH: rd = st_reg.ml_hi;
            APP_IDX_MIX_R_LOW:  rd = {st_reg.mr_lo, 12'h000};
            APP_IDX_MIX_R_HIGH: rd = st_reg.mr_hi;
            default:            rd = APP_REG_RESET;
        endcase

        // One wait cycle, then a single acknowledge cycle
        case (st_reg.bus_state)
            APP_BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    st_next.bus_state = APP_BUS_ACK;
                    st_next.wait_q = 1'b0;
                    st_next.rdata = {16'h0000, rd};
                end
            end
            APP_BUS_ACK:
            begin
                st_next.bus_state = APP_BUS_IDLE;
                st_next.wait_q = 1'b1;
            end
            default:
            begin
                st_next.bus_state = APP_BUS_IDLE;
                st_next.wait_q = 1'b1;
            end
        endcase

        // Writes land on the acknowledge edge
        if (wr_go)
        begin
            case (idx)
                APP_IDX_RATE_LOW:
                    st_next.rate_lo = app_merge(st_reg.rate_lo, wdat, be);
                APP_IDX_RATE_HIGH:
                    if (be[0])
                        st_next.rate_hi = wdat[3:0]; // see [R1]
                APP_IDX_LEFT_LOW:
                    if (be[1])
                        st_next.left_lo = wdat[15:8];
                APP_IDX_LEFT_HIGH:
                    st_next.left_hi = app_merge(st_reg.left_hi, wdat, be);
                APP_IDX_RIGHT_LOW:
                    if (be[1])
                        st_next.right_lo = wdat[15:8];
                APP_IDX_RIGHT_HIGH:
                    st_next.right_hi = app_merge(st_reg.right_hi, wdat, be);
                APP_IDX_ROUTE:
                    if (be[0])
                        st_next.route_mix = wdat[0];
                APP_IDX_VOLUME:
                    st_next.volume = app_merge(st_reg.volume, wdat, be);
                APP_IDX_MIX_CONFIG:
                begin
                    if (be[0])
                        st_next.mix_int[7:0] = wdat[7:0];
                    if (be[1])
                    begin
                        st_next.mix_int[11:8] = wdat[11:8];
                        st_next.mix_en = wdat[APP_MIX_EN_BIT]; // see [R12]
                        urun_clr = wdat[APP_MIX_URUN_BIT];
                    end
                end
                APP_IDX_MIX_L_LOW:
                    if (be[1])
                        st_next.ml_lo = wdat[15:12];
                APP_IDX_MIX_L_HIGH:
                begin
                    st_next.ml_hi = app_merge(st_reg.ml_hi, wdat, be);
                    seen_l_now = 1'b1;
                end
                APP_IDX_MIX_R_LOW:
                    if (be[1])
                        st_next.mr_lo = wdat[15:12];
                APP_IDX_MIX_R_HIGH:
                begin
                    st_next.mr_hi = app_merge(st_reg.mr_hi, wdat, be);
                    seen_r_now = 1'b1;
                end
                default:
                    ; // Unmapped: ignored
            endcase
        end

        // Pair complete on both high writes
        full_set = seen_l_now && seen_r_now; // see [R14]
        st_next.seen_l = seen_l_now && !full_set;
        st_next.seen_r = seen_r_now && !full_set;

        // Offset interval counter
        consume = st_reg.mix_en && (st_reg.mix_cnt >= st_reg.mix_int);
        if (!st_reg.mix_en || consume)
            st_next.mix_cnt = 12'h000; // see [R16]
        else
            st_next.mix_cnt = st_reg.mix_cnt + 12'h001;

        // Held offset sample; stale value kept on underrun
        if (consume && st_reg.full)
        begin
            st_next.off_l = {st_reg.ml_hi, st_reg.ml_lo}; // see [R13] [R11]
            st_next.off_r = {st_reg.mr_hi, st_reg.mr_lo}; // see [R13] [R11]
        end
        st_next.mix_irq = consume; // see [R17]

        // Set beats clear on both flags
        st_next.full = full_set || (st_reg.full && !consume); // see [R14]
        st_next.urun = (consume && !st_reg.full) ||
                       (st_reg.urun && !urun_clr); // see [R15]

        // Interpolator steps once per 128 cycles
        inc = {st_reg.rate_hi, st_reg.rate_lo}; // see [R1]
        acc_sum = {1'b0, st_reg.acc} + {1'b0, inc};
        strobe = 1'b0;
        st_next.play_irq = 1'b0;
        st_next.clk_en = (inc != 20'h00000); // see [R4] [R7]
        if (inc != 20'h00000)
        begin
            st_next.pre = st_reg.pre + 7'h01; // see [R3]
            if (st_reg.pre == APP_PRESCALE_TOP)
            begin
                st_next.acc = acc_sum[19:0]; // see [R2]
                strobe = acc_sum[20]; // see [R2]
            end

            // Whole pair captured in one edge
            if (strobe)
            begin
                st_next.in_l = {st_reg.left_hi, st_reg.left_lo}; // see [R5] [R21]
                st_next.in_r = {st_reg.right_hi, st_reg.right_lo}; // see [R21]
                st_next.play_irq = 1'b1; // Prompts refill, see [R6]
            end

            // Filter, volume, then mix
            st_next.flt_l = app_smooth(st_reg.flt_l, st_reg.in_l); // see [R10]
            st_next.flt_r = app_smooth(st_reg.flt_r, st_reg.in_r); // see [R10]
            st_next.vol_l = app_volume(st_reg.flt_l, st_reg.volume[11:8],
                                       st_reg.volume[15:12]); // see [R10]
            st_next.vol_r = app_volume(st_reg.flt_r, st_reg.volume[3:0],
                                       st_reg.volume[7:4]); // see [R10]
            st_next.dac_l = app_mix(st_reg.vol_l, st_reg.off_l,
                                    st_reg.mix_en); // see [R18]
            st_next.dac_r = app_mix(st_reg.vol_r, st_reg.off_r,
                                    st_reg.mix_en); // see [R18]
        end

        // Serial output source select
        if (st_reg.route_mix)
        begin
            st_next.ser_l = {st_reg.dac_l, 4'h0}; // see [R20]
            st_next.ser_r = {st_reg.dac_r, 4'h0}; // see [R20]
        end
        else
        begin
            st_next.ser_l = ser_direct_left;
            st_next.ser_r = ser_direct_right;
        end
    end

    // State register; reset leaves the path idle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
            st_reg.bus_state <= APP_BUS_IDLE;
            st_reg.wait_q <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state flops
    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.wait_q;
    assign dac_left        = st_reg.dac_l;
    assign dac_right       = st_reg.dac_r;
    assign dac_clk_en      = st_reg.clk_en;
    assign play_irq        = st_reg.play_irq;
    assign mix_irq         = st_reg.mix_irq;
    assign ser_left        = st_reg.ser_l;
    assign ser_right       = st_reg.ser_r;

endmodule

/* File: app_playback_properties.sv */
// Purpose: Port properties of the playback path.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes:   Bound to app_playback below.
`timescale 1ns/1ps
module app_playback_properties
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [23:0] ser_direct_left,
    input wire logic [23:0] ser_direct_right,
    input wire logic [19:0] dac_left,
    input wire logic [19:0] dac_right,
    input wire logic        dac_clk_en,
    input wire logic        play_irq,
    input wire logic        mix_irq,
    input wire logic [23:0] ser_left,
    input wire logic [23:0] ser_right
);
    logic [7:0] gap_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Cycles since last request, saturating
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            gap_reg <= 8'hff;
        else if (play_irq)
            gap_reg <= 8'h00;
        else if (gap_reg != 8'hff)
            gap_reg <= gap_reg + 8'h01;
    end

    property p_wait_short;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_short: assert property (p_wait_short)
        else $error("wait low too long");

    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer");

    property p_upper_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper lanes set");

    property p_ser_left;
        ser_left == {$past(dac_left), 4'h0} || ser_left == $past(ser_direct_left);
    endproperty
    a_ser_left: assert property (p_ser_left)
        else $error("bad left serial");

    property p_ser_right;
        ser_right == {$past(dac_right), 4'h0}
            || ser_right == $past(ser_direct_right);
    endproperty
    a_ser_right: assert property (p_ser_right)
        else $error("bad right serial");

    // One rollover per 128-cycle step at most
    property p_gap;
        play_irq |-> gap_reg >= 8'h7f;
    endproperty
    a_gap: assert property (p_gap)
        else $error("requests too close");

    property p_idle;
        !dac_clk_en && !$past(dac_clk_en) |-> !play_irq;
    endproperty
    a_idle: assert property (p_idle)
        else $error("request while idle");

    property p_clk_cause;
        $changed(dac_clk_en) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_clk_cause: assert property (p_clk_cause)
        else $error("clock change without write");

    c_play: cover property (play_irq);
    c_mix: cover property (mix_irq);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind app_playback app_playback_properties i_props
(
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .avs_read (avs_read),
    .avs_write (avs_write),
    .avs_readdata (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ser_direct_left (ser_direct_left),
    .ser_direct_right (ser_direct_right),
    .dac_left (dac_left),
    .dac_right (dac_right),
    .dac_clk_en (dac_clk_en),
    .play_irq (play_irq),
    .mix_irq (mix_irq),
    .ser_left (ser_left),
    .ser_right (ser_right)
);

/* File: app_dac_model.sv */
// Purpose: Behavioural converter modulator on the far side.
// Assumes: Crystal clock.
// Notes:   Holds last words, counts samples.
`timescale 1ns/1ps
module app_dac_model
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        dac_clk_en,
    input  wire logic [19:0] dac_left,
    input  wire logic [19:0] dac_right,
    output logic      [19:0] seen_left,
    output logic      [19:0] seen_right,
    output logic      [15:0] seen_cnt
);
    // Takes words only while clock runs
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            seen_left  <= 20'h00000;
            seen_right <= 20'h00000;
            seen_cnt   <= 16'h0000;
        end
        else if (dac_clk_en)
        begin
            seen_left  <= dac_left;
            seen_right <= dac_right;
            seen_cnt   <= seen_cnt + 16'h0001;
        end
    end
endmodule

/* File: tb_top.sv */
// Purpose: Bench for the playback path.
// Assumes: 25 MHz clock.
// Notes:   Read notes queue to a monitor.
`timescale 1ns/1ps
module tb_top
    import app_pkg::*;
;
    logic        core_clk, sys_rst, avs_read, avs_write;
    logic        avs_waitrequest, dac_clk_en, play_irq, mix_irq;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [23:0] ser_direct_left, ser_direct_right, ser_left, ser_right;
    logic [19:0] dac_left, dac_right, seen_left, seen_right;
    logic [31:0] exp_q [$];
    int          error_cnt = 0;
    int          checks    = 0;
    int          cyc       = 0;
    logic [15:0] idx_tab [13] = '{APP_IDX_RATE_LOW, APP_IDX_RATE_HIGH,
        APP_IDX_LEFT_LOW, APP_IDX_LEFT_HIGH, APP_IDX_RIGHT_LOW,
        APP_IDX_RIGHT_HIGH, APP_IDX_ROUTE, APP_IDX_VOLUME, APP_IDX_MIX_CONFIG,
        APP_IDX_MIX_L_LOW, APP_IDX_MIX_L_HIGH, APP_IDX_MIX_R_LOW,
        APP_IDX_MIX_R_HIGH};
    logic [15:0] msk_tab [13] = '{16'hffff, 16'h000f, 16'hff00, 16'hffff,
        16'hff00, 16'hffff, 16'h0001, 16'hffff, 16'h0000, 16'hf000, 16'hffff,
        16'hf000, 16'hffff};
    logic [19:0] inc_tab [3] = '{20'h80000, 20'hfffff, 20'h40000};
    logic [39:0] gap_tab [3] = '{40'h100, 40'h80, 40'h200};
    logic [15:0] vol_tab [3] = '{16'h0000, 16'hc1c2, 16'hb0b0};
    logic [39:0] out_tab [3] = '{{20'h7ffff, 20'hb0000},
        {20'h3ffff, 20'hec000}, {20'h7ffff, 20'h80000}};

    app_playback i_app_playback
    (
        .core_clk (core_clk),
        .sys_rst (sys_rst),
        .avs_address (avs_address),
        .avs_read (avs_read),
        .avs_write (avs_write),
        .avs_writedata (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .ser_direct_left (ser_direct_left),
        .ser_direct_right (ser_direct_right),
        .dac_left (dac_left),
        .dac_right (dac_right),
        .dac_clk_en (dac_clk_en),
        .play_irq (play_irq),
        .mix_irq (mix_irq),
        .ser_left (ser_left),
        .ser_right (ser_right)
    );

    app_dac_model i_app_dac_model
    (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .dac_clk_en (dac_clk_en),
        .dac_left   (dac_left),
        .dac_right  (dac_right),
        .seen_left  (seen_left),
        .seen_right (seen_right),
        .seen_cnt   ()
    );

    // 25 MHz crystal clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("BAD %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One access, held until waitrequest low
    task automatic bus(input logic [15:0] idx, input bit wr,
                       input logic [15:0] d);
        avs_address   <= {idx, 2'b00};
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {16'h0000, d};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(idx, 1'b0, 16'h0000);
    endtask

    // Gap between two pulses
    task automatic pulse_gap(input bit sel, output int g);
        g = 0;
        @(posedge core_clk);
        while ((sel ? mix_irq : play_irq) !== 1'b1)
            @(posedge core_clk);
        do
        begin
            @(posedge core_clk);
            g++;
        end while ((sel ? mix_irq : play_irq) !== 1'b1);
    endtask

    // Read checker and hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check({8'h00, avs_readdata}, {8'h00, exp_q.pop_front()});
        if (cyc == 30000)
        begin
            error_cnt++;
            close_out();
        end
    end

    initial
    begin
        logic [15:0] d;
        logic [11:0] iv;
        int          g;
        int          n;
        sys_rst          = 1'b1;
        avs_address      = 18'h00000;
        avs_read         = 1'b0;
        avs_write        = 1'b0;
        avs_writedata    = 32'h00000000;
        avs_byteenable   = 4'hf;
        ser_direct_left  = 24'h000000;
        ser_direct_right = 24'h000000;
        d = 16'($urandom(32'h44b6cfa6));
        repeat (4) @(posedge core_clk);
        sys_rst          <= 1'b0;
        ser_direct_left  <= 24'($urandom);
        ser_direct_right <= 24'($urandom);
        @(posedge core_clk);
        // Reset values, widths, unmapped
        foreach (idx_tab[i])
            rd(idx_tab[i], APP_REG_RESET);
        rd(16'h1234, 16'h0000);
        foreach (idx_tab[i])
        begin
            d = 16'($urandom);
            if (i != 8)
            begin
                bus(idx_tab[i], 1'b1, d);
                rd(idx_tab[i], d & msk_tab[i]);
            end
        end
        // Request spacing
        foreach (inc_tab[i])
        begin
            bus(APP_IDX_RATE_LOW, 1'b1, inc_tab[i][15:0]);
            bus(APP_IDX_RATE_HIGH, 1'b1, {12'h000, inc_tab[i][19:16]});
            pulse_gap(1'b0, g);
            pulse_gap(1'b0, g);
            check(40'(g), gap_tab[i]);
        end
        // Volume on settled samples
        bus(APP_IDX_LEFT_LOW, 1'b1, 16'hff00);
        bus(APP_IDX_LEFT_HIGH, 1'b1, 16'h7fff);
        bus(APP_IDX_RIGHT_LOW, 1'b1, 16'h0800);
        bus(APP_IDX_RIGHT_HIGH, 1'b1, 16'hb000);
        bus(APP_IDX_ROUTE, 1'b1, 16'h0001);
        foreach (vol_tab[i])
        begin
            bus(APP_IDX_VOLUME, 1'b1, vol_tab[i]);
            repeat (1200) @(posedge core_clk);
            check({seen_left, seen_right}, out_tab[i]);
        end
        check(40'(ser_left), {16'h0, 20'h7ffff, 4'h0});
        bus(APP_IDX_ROUTE, 1'b1, 16'h0000);
        repeat (3) @(posedge core_clk);
        check(40'(ser_left), 40'(ser_direct_left));
        // Offset flags, rate, mix
        bus(APP_IDX_VOLUME, 1'b1, 16'h0000);
        bus(APP_IDX_MIX_L_LOW, 1'b1, 16'hf000);
        bus(APP_IDX_MIX_L_HIGH, 1'b1, 16'h7fff);
        bus(APP_IDX_MIX_R_LOW, 1'b1, 16'h0000);
        bus(APP_IDX_MIX_R_HIGH, 1'b1, 16'h0010);
        rd(APP_IDX_MIX_CONFIG, 16'h2000);
        iv = 12'($urandom_range(40, 1));
        bus(APP_IDX_MIX_CONFIG, 1'b1, {4'h1, iv});
        pulse_gap(1'b1, g);
        check(40'(g), 40'(iv) + 40'h1);
        rd(APP_IDX_MIX_CONFIG, {4'h5, iv});
        repeat (20) @(posedge core_clk);
        check({seen_left, seen_right}, {20'h7ffff, 20'hb0100});
        // Zero increment idles
        bus(APP_IDX_RATE_LOW, 1'b1, 16'h0000);
        bus(APP_IDX_RATE_HIGH, 1'b1, 16'h0000);
        n = 0;
        repeat (600)
        begin
            @(posedge core_clk);
            n += (play_irq === 1'b1);
        end
        check({39'h0, dac_clk_en}, 40'h0);
        check(40'(n), 40'h0);
        close_out();
    end
endmodule
